//--- hw/mam_engine.sv
`timescale 1ns/1ps
`default_nettype none
module mam_engine (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_link_up,
  input  wire logic         i_rx_valid,
  input  wire logic [7:0]   i_rx_data,
  output logic              o_rx_ready,
  output logic              o_tx_valid,
  output logic [7:0]        o_tx_data,
  input  wire logic         i_tx_ready,
  output logic              o_rand_req,
  input  wire logic         i_rand_valid,
  input  wire logic [127:0] i_rand_data,
  output logic              o_aes_start,
  output logic              o_aes_decrypt,
  output logic [127:0]      o_aes_key,
  output logic [127:0]      o_aes_block,
  input  wire logic         i_aes_done,
  input  wire logic [127:0] i_aes_result,
  input  wire logic         i_key_wr,
  input  wire logic [127:0] i_key_wr_data,
  output logic              o_authenticated,
  output logic [127:0]      o_session_key,
  output logic              o_data_req
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  mam_pkg::mam_rx_e rx_q;
  mam_pkg::mam_st_e st_q;
  logic [7:0]   type_q;
  logic [15:0]  len_q;
  logic [15:0]  cnt_q;
  logic [7:0]   frame_xor_sum_q;
  logic         frame_done_q;
  logic         sum_ok_q;
  logic [7:0]   auth_payload_q [mam_pkg::PAY_BYTES];
  logic [127:0] reader_nonce_q;
  logic [127:0] peer_nonce_q;
  logic [127:0] session_key_q;
  logic [127:0] key_q;
  logic         auth_q;
  logic         challenged_q;
  logic         aes_go_q;
  logic         data_req_q;
  logic [7:0]   tx_type_q;
  logic [15:0]  tx_len_q;
  logic [127:0] tx_body_q;
  logic [15:0]  tx_idx_q;
  logic [7:0]   tx_sum_q;
  logic [7:0]   tx_byte;
  logic         tx_last;
  logic         take;
  logic         disp;
  logic [127:0] blk_lo;
  logic [127:0] blk_hi;
  logic [127:0] plain_hi;
  logic         nonce_match;

  mam_stream_if #(.W(mam_pkg::BYTE_W)) push_s ();
  mam_stream_if #(.W(mam_pkg::BYTE_W)) pop_s ();

  ////////////////////////////////////////////////////////////////////////
  // Frame receiver
  // Ready drops for the dispatch cycle so a back-to-back frame cannot
  // overwrite the type and length still being judged.
  assign o_rx_ready = (st_q == mam_pkg::ST_IDLE) && !frame_done_q;
  assign take = i_rx_valid && o_rx_ready;
  assign disp = (st_q == mam_pkg::ST_IDLE) && frame_done_q;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rx_q            <= mam_pkg::RX_TYPE;
      type_q          <= '0;
      len_q           <= '0;
      cnt_q           <= '0;
      frame_xor_sum_q <= '0;
      frame_done_q    <= 1'b0;
      sum_ok_q        <= 1'b0;
    end else begin
      frame_done_q <= 1'b0;
      if (take) begin
        frame_xor_sum_q <= frame_xor_sum_q ^ i_rx_data;
        unique case (rx_q)
          mam_pkg::RX_TYPE: begin
            type_q          <= i_rx_data;
            frame_xor_sum_q <= i_rx_data;
            cnt_q           <= '0;
            rx_q            <= mam_pkg::RX_LEN_LO;
          end
          mam_pkg::RX_LEN_LO: begin
            len_q[7:0] <= i_rx_data;
            rx_q       <= mam_pkg::RX_LEN_HI;
          end
          mam_pkg::RX_LEN_HI: begin
            len_q[15:8] <= i_rx_data;
            if ({i_rx_data, len_q[7:0]} == '0) begin
              // No room for a checksum: judged as a bad frame
              frame_done_q <= 1'b1;
              sum_ok_q     <= 1'b0;
              rx_q         <= mam_pkg::RX_TYPE;
            end else begin
              rx_q <= mam_pkg::RX_BODY;
            end
          end
          mam_pkg::RX_BODY: begin
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q == 16'(len_q - 16'h0001)) begin
              frame_done_q <= 1'b1;
              sum_ok_q     <= (frame_xor_sum_q == i_rx_data);
              rx_q         <= mam_pkg::RX_TYPE;
            end
          end
        endcase
      end
    end
  end

  // Bytes past the 32nd are checked but not stored
  always_ff @(posedge i_clk) begin
    if (take && rx_q == mam_pkg::RX_BODY && cnt_q < 16'(mam_pkg::PAY_BYTES)) begin
      auth_payload_q[cnt_q[4:0]] <= i_rx_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cipher block assembly
  always_comb begin
    blk_lo = '0;
    blk_hi = '0;
    for (int i = 0; i < 16; i++) begin
      blk_lo[127-8*i -: 8] = auth_payload_q[i];
      blk_hi[127-8*i -: 8] = auth_payload_q[16+i];
    end
  end

  // Second CBC block chains on the first ciphertext block
  assign plain_hi    = i_aes_result ^ blk_lo;
  assign nonce_match = (plain_hi == reader_nonce_q);

  always_comb begin
    unique case (st_q)
      mam_pkg::ST_ENC:  o_aes_block = reader_nonce_q ^ mam_pkg::CBC_IV;
      mam_pkg::ST_ENC2: o_aes_block = peer_nonce_q ^ mam_pkg::CBC_IV;
      mam_pkg::ST_DEC0: o_aes_block = blk_lo;
      mam_pkg::ST_DEC1: o_aes_block = blk_hi;
      default:          o_aes_block = '0;
    endcase
  end

  assign o_aes_decrypt = (st_q == mam_pkg::ST_DEC0) || (st_q == mam_pkg::ST_DEC1);
  assign o_aes_start   = aes_go_q;
  assign o_aes_key     = key_q;
  assign o_rand_req    = (st_q == mam_pkg::ST_RAND);

  ////////////////////////////////////////////////////////////////////////
  // Message sequencer
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_q           <= mam_pkg::ST_IDLE;
      aes_go_q       <= 1'b0;
      data_req_q     <= 1'b0;
      auth_q         <= 1'b0;
      challenged_q   <= 1'b0;
      reader_nonce_q <= '0;
      peer_nonce_q   <= '0;
      session_key_q  <= '0;
      tx_type_q      <= '0;
      tx_len_q       <= '0;
      tx_body_q      <= '0;
    end else begin
      aes_go_q   <= 1'b0;
      data_req_q <= 1'b0;
      unique case (st_q)
        mam_pkg::ST_IDLE: begin
          if (!i_link_up) begin
            auth_q       <= 1'b0;
            challenged_q <= 1'b0;
          end else if (disp) begin
            st_q      <= mam_pkg::ST_SEND;
            tx_type_q <= mam_pkg::TYPE_ERR_ACK;
            tx_len_q  <= mam_pkg::LEN_ACK;
            if (!sum_ok_q) begin
              tx_body_q <= {mam_pkg::ERR_SUM, 120'h0};
            end else if (type_q == mam_pkg::TYPE_AUTH_REQ) begin
              if (len_q != mam_pkg::LEN_AUTH_REQ) begin
                tx_body_q <= {mam_pkg::ERR_LEN, 120'h0};
              end else begin
                auth_q       <= 1'b0;
                challenged_q <= 1'b0;
                st_q         <= mam_pkg::ST_RAND;
              end
            end else if (type_q == mam_pkg::TYPE_PEER_REPLY) begin
              challenged_q <= 1'b0;
              if (!challenged_q) begin
                tx_body_q <= {mam_pkg::ERR_STATE, 120'h0};
              end else if (len_q != mam_pkg::LEN_PEER_REPLY) begin
                tx_body_q <= {mam_pkg::ERR_LEN, 120'h0};
              end else begin
                st_q     <= mam_pkg::ST_DEC0;
                aes_go_q <= 1'b1;
              end
            end else if (type_q == mam_pkg::TYPE_DATA_REQ && auth_q) begin
              // Inner command bodies are handled outside this engine
              data_req_q <= 1'b1;
              tx_type_q  <= mam_pkg::TYPE_DATA_RSP;
              tx_len_q   <= mam_pkg::LEN_DATA_RSP;
            end else begin
              tx_body_q <= {mam_pkg::ERR_STATE, 120'h0};
            end
          end
        end
        mam_pkg::ST_RAND: begin
          if (i_rand_valid) begin
            reader_nonce_q <= i_rand_data;
            st_q           <= mam_pkg::ST_ENC;
            aes_go_q       <= 1'b1;
          end
        end
        mam_pkg::ST_ENC: begin
          if (i_aes_done) begin
            tx_type_q    <= mam_pkg::TYPE_CHALLENGE;
            tx_len_q     <= mam_pkg::LEN_NONCE;
            tx_body_q    <= i_aes_result;
            challenged_q <= 1'b1;
            st_q         <= mam_pkg::ST_SEND;
          end
        end
        mam_pkg::ST_DEC0: begin
          if (i_aes_done) begin
            peer_nonce_q <= i_aes_result ^ mam_pkg::CBC_IV;
            st_q         <= mam_pkg::ST_DEC1;
            aes_go_q     <= 1'b1;
          end
        end
        mam_pkg::ST_DEC1: begin
          if (i_aes_done) begin
            if (nonce_match) begin
              auth_q        <= 1'b1;
              session_key_q <= {reader_nonce_q[127:64], peer_nonce_q[127:64]};
              st_q          <= mam_pkg::ST_ENC2;
              aes_go_q      <= 1'b1;
            end else begin
              tx_type_q <= mam_pkg::TYPE_ERR_ACK;
              tx_len_q  <= mam_pkg::LEN_ACK;
              tx_body_q <= {mam_pkg::ERR_AUTH, 120'h0};
              st_q      <= mam_pkg::ST_SEND;
            end
          end
        end
        mam_pkg::ST_ENC2: begin
          if (i_aes_done) begin
            tx_type_q <= mam_pkg::TYPE_COMPLETE;
            tx_len_q  <= mam_pkg::LEN_NONCE;
            tx_body_q <= i_aes_result;
            st_q      <= mam_pkg::ST_SEND;
          end
        end
        mam_pkg::ST_SEND: begin
          if (push_s.ready) begin
            if (tx_idx_q > 16'h0002) begin
              tx_body_q <= {tx_body_q[119:0], 8'h00};
            end
            if (tx_last) begin
              st_q <= mam_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Customer key store
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      key_q <= mam_pkg::KEY_RESET;
    end else if (i_key_wr && auth_q) begin
      key_q <= i_key_wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame transmitter: header and checksum go out in clear
  assign tx_last = (tx_idx_q == 16'(tx_len_q + mam_pkg::HDR_AFTER_TYPE));

  always_comb begin
    if (tx_idx_q == 16'h0000) begin
      tx_byte = tx_type_q;
    end else if (tx_idx_q == 16'h0001) begin
      tx_byte = tx_len_q[7:0];
    end else if (tx_idx_q == 16'h0002) begin
      tx_byte = tx_len_q[15:8];
    end else if (tx_last) begin
      tx_byte = tx_sum_q;
    end else begin
      tx_byte = tx_body_q[127:120];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n || st_q != mam_pkg::ST_SEND) begin
      tx_idx_q <= '0;
      tx_sum_q <= '0;
    end else if (push_s.ready) begin
      tx_idx_q <= tx_idx_q + 16'h0001;
      tx_sum_q <= tx_sum_q ^ tx_byte;
    end
  end

  assign push_s.valid = (st_q == mam_pkg::ST_SEND);
  assign push_s.data  = tx_byte;
  assign o_tx_valid   = pop_s.valid;
  assign o_tx_data    = pop_s.data;
  assign pop_s.ready  = i_tx_ready;

  mam_fifo #(
    .W     (mam_pkg::BYTE_W),
    .DEPTH (mam_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .in_s      (push_s),
    .out_s     (pop_s)
  );

  assign o_authenticated = auth_q;
  assign o_session_key   = session_key_q;
  assign o_data_req      = data_req_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_good_req;
    disp && i_link_up && sum_ok_q && type_q == mam_pkg::TYPE_AUTH_REQ
      && len_q == mam_pkg::LEN_AUTH_REQ;
  endsequence
  sequence s_challenge_out;
    st_q == mam_pkg::ST_ENC && i_aes_done;
  endsequence

  AST_DATA_NEEDS_AUTH: assert property (o_data_req |-> $past(auth_q))
    else $error("data request accepted without authentication");
  AST_REQ_GETS_NONCE: assert property (s_good_req |=> o_rand_req)
    else $error("auth request did not fetch a nonce");
  AST_CHALLENGE_FRAME: assert property (s_challenge_out |=>
    tx_type_q == mam_pkg::TYPE_CHALLENGE && tx_len_q == mam_pkg::LEN_NONCE
    && tx_body_q == $past(i_aes_result))
    else $error("challenge frame fields wrong");
  AST_BAD_SUM_ACK: assert property (disp && i_link_up && !sum_ok_q |=>
    tx_type_q == mam_pkg::TYPE_ERR_ACK && tx_body_q[127:120] == mam_pkg::ERR_SUM)
    else $error("bad checksum not acknowledged as error");
  AST_AUTH_ON_MATCH: assert property ($rose(auth_q) |-> $past(nonce_match))
    else $error("authenticated without nonce match");
  AST_SESSION_KEY: assert property ($rose(auth_q) |->
    session_key_q == {reader_nonce_q[127:64], peer_nonce_q[127:64]})
    else $error("session key not formed from nonce halves");
  AST_KEY_LOCK: assert property ($changed(key_q) |-> $past(auth_q))
    else $error("customer key changed before authentication");
  AST_DATA_ANSWER: assert property (o_data_req |->
    st_q == mam_pkg::ST_SEND && tx_type_q == mam_pkg::TYPE_DATA_RSP)
    else $error("data request not answered with data response");
  AST_TX_SUM: assert property (push_s.valid && push_s.ready && tx_last |->
    push_s.data == tx_sum_q)
    else $error("outgoing checksum wrong");
  AST_STATE_REJECT: assert property (disp && i_link_up && sum_ok_q && !auth_q
    && type_q == mam_pkg::TYPE_DATA_REQ |=> tx_type_q == mam_pkg::TYPE_ERR_ACK ##0
    tx_body_q[127:120] == mam_pkg::ERR_STATE)
    else $error("data request before authentication not rejected");
endmodule : mam_engine
`default_nettype wire

//--- pkg/mam_pkg.sv
`default_nettype none
package mam_pkg;
  // Message type bytes
  localparam logic [7:0] TYPE_AUTH_REQ   = 8'h70;
  localparam logic [7:0] TYPE_PEER_REPLY = 8'h71;
  localparam logic [7:0] TYPE_DATA_REQ   = 8'h72;
  localparam logic [7:0] TYPE_CHALLENGE  = 8'h20;
  localparam logic [7:0] TYPE_COMPLETE   = 8'h21;
  localparam logic [7:0] TYPE_DATA_RSP   = 8'h22;
  localparam logic [7:0] TYPE_ERR_ACK    = 8'h23;
  // Length field values (bytes after the length field, checksum included)
  localparam logic [15:0] LEN_AUTH_REQ   = 16'h0001;
  localparam logic [15:0] LEN_NONCE      = 16'h0011;
  localparam logic [15:0] LEN_PEER_REPLY = 16'h0021;
  localparam logic [15:0] LEN_ACK        = 16'h0002;
  localparam logic [15:0] LEN_DATA_RSP   = 16'h0001;
  localparam logic [15:0] HDR_AFTER_TYPE = 16'h0002;
  // Error codes carried by the acknowledge message
  localparam logic [7:0] ERR_SUM   = 8'h01;
  localparam logic [7:0] ERR_LEN   = 8'h02;
  localparam logic [7:0] ERR_STATE = 8'h03;
  localparam logic [7:0] ERR_AUTH  = 8'h04;
  // Cipher constants
  localparam logic [127:0] CBC_IV    = 128'h0;
  localparam logic [127:0] KEY_RESET = 128'h0;
  localparam int unsigned  PAY_BYTES = 32;
  localparam logic [4:0]   BODY_NONCE = 5'h10;
  localparam logic [4:0]   BODY_ACK   = 5'h01;
  localparam logic [4:0]   BODY_NONE  = 5'h00;
  // Outgoing FIFO shape
  localparam int unsigned  BYTE_W     = 8;
  localparam int unsigned  FIFO_DEPTH = 8;

  typedef enum logic [1:0] {RX_TYPE, RX_LEN_LO, RX_LEN_HI, RX_BODY} mam_rx_e;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RAND, ST_ENC, ST_DEC0, ST_DEC1, ST_ENC2, ST_SEND
  } mam_st_e;
endpackage : mam_pkg
`default_nettype wire

//--- pkg/mam_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mam_stream_if #(parameter int unsigned W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : mam_stream_if
`default_nettype wire

//--- hw/mam_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module mam_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic     i_clk,
  input  wire logic     i_reset_n,
  mam_stream_if.snk     in_s,
  mam_stream_if.src     out_s
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_s.ready  = (cnt_q != FULL_CNT);
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data  = mem_q[rd_q];
  assign push = in_s.valid && in_s.ready;
  assign pop  = out_s.valid && out_s.ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_s.data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : mam_fifo
`default_nettype wire

//--- verification/mam_cipher_model.sv
`timescale 1ns/1ps
`default_nettype none
module mam_cipher_model #(
  parameter logic [127:0] NONCE_BASE = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_slow,
  input  wire logic         i_rand_req,
  output logic              o_rand_valid,
  output logic [127:0]      o_rand_data,
  input  wire logic         i_start,
  input  wire logic         i_decrypt,
  input  wire logic [127:0] i_key,
  input  wire logic [127:0] i_block,
  output logic              o_done,
  output logic [127:0]      o_result,
  output logic [127:0]      o_last_nonce
);
  int unsigned  cnt;
  int unsigned  rcnt;
  logic [127:0] t;
  logic [127:0] nxt;

  initial begin
    o_rand_valid = 1'b0;
    o_rand_data  = 128'h0;
    o_done       = 1'b0;
    o_result     = 128'h0;
    o_last_nonce = NONCE_BASE;
    cnt          = 0;
    rcnt         = 0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Toy cipher: key xor plus byte rotate, so direction and key both matter
  always @(negedge i_clk) begin
    o_done       <= 1'b0;
    o_rand_valid <= 1'b0;
    // Outputs outside a valid cycle invert each cycle, so they show the last value only every other cycle
    o_result     <= ~o_result;
    o_rand_data  <= ~o_rand_data;
    if (!i_reset_n) begin
      cnt  = 0;
      rcnt = 0;
    end else begin
      if (i_start) begin
        cnt = i_slow ? 12 : 1;
      end else if (cnt != 0) begin
        cnt--;
        if (cnt == 0) begin
          o_done <= 1'b1;
          if (i_decrypt) begin
            o_result <= {i_block[7:0], i_block[127:8]} ^ i_key;
          end else begin
            t = i_block ^ i_key;
            o_result <= {t[119:0], t[127:120]};
          end
        end
      end
      if (!i_rand_req) begin
        rcnt = 0;
      end else begin
        if (rcnt == (i_slow ? 5 : 0)) begin
          nxt = o_last_nonce + 128'h1111;
          o_rand_valid <= 1'b1;
          o_rand_data  <= nxt;
          o_last_nonce <= nxt;
        end
        rcnt++;
      end
    end
  end
endmodule : mam_cipher_model
`default_nettype wire

//--- verification/tb_mutual_auth_message_engine.sv
`timescale 1ns/1ps
`default_nettype none
module tb_mutual_auth_message_engine;
  typedef logic [7:0] mam_tb_q_t[$];
  typedef struct { logic [39:0] fr; int n; logic [7:0] code; } mam_tb_row_s;
  localparam logic [127:0] PEER    = 128'hA1B2_C3D4_E5F6_0718_293A_4B5C_6D7E_8F90;
  localparam logic [127:0] KEY_NEW = 128'h5A5A_0F0F_3C3C_9696_1234_5678_9ABC_DEF0;

  logic         i_clk, i_reset_n, i_link_up, i_rx_valid, o_rx_ready;
  logic [7:0]   i_rx_data, o_tx_data;
  logic         o_tx_valid, i_tx_ready, o_rand_req, i_rand_valid;
  logic [127:0] i_rand_data, o_aes_key, o_aes_block, i_aes_result;
  logic         o_aes_start, o_aes_decrypt, i_aes_done, i_key_wr;
  logic [127:0] i_key_wr_data, o_session_key, last_nonce, rn, c0, c1, key_m;
  logic         o_authenticated, o_data_req, slow;
  int           err_total, n_checks, dreq_cnt, w;
  mam_tb_q_t    got_q, none;
  mam_tb_row_s  rows [6] = '{
    '{40'h70_01_00_70_00, 4, mam_pkg::ERR_SUM},
    '{40'h70_00_00_00_00, 3, mam_pkg::ERR_SUM},
    '{40'h70_02_00_00_72, 5, mam_pkg::ERR_LEN},
    '{40'h71_01_00_70_00, 4, mam_pkg::ERR_STATE},
    '{40'h72_01_00_73_00, 4, mam_pkg::ERR_STATE},
    '{40'h55_01_00_54_00, 4, mam_pkg::ERR_STATE}};

  mam_engine dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_link_up(i_link_up),
    .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .o_rx_ready(o_rx_ready),
    .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready),
    .o_rand_req(o_rand_req), .i_rand_valid(i_rand_valid), .i_rand_data(i_rand_data),
    .o_aes_start(o_aes_start), .o_aes_decrypt(o_aes_decrypt), .o_aes_key(o_aes_key),
    .o_aes_block(o_aes_block), .i_aes_done(i_aes_done), .i_aes_result(i_aes_result),
    .i_key_wr(i_key_wr), .i_key_wr_data(i_key_wr_data),
    .o_authenticated(o_authenticated), .o_session_key(o_session_key),
    .o_data_req(o_data_req));

  mam_cipher_model partner (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_slow(slow),
    .i_rand_req(o_rand_req), .o_rand_valid(i_rand_valid), .o_rand_data(i_rand_data),
    .i_start(o_aes_start), .i_decrypt(o_aes_decrypt), .i_key(o_aes_key),
    .i_block(o_aes_block), .o_done(i_aes_done), .o_result(i_aes_result),
    .o_last_nonce(last_nonce));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    if (o_tx_valid && i_tx_ready) got_q.push_back(o_tx_data);
    if (o_data_req) dreq_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [127:0] enc(input logic [127:0] b);
    logic [127:0] t;
    t = b ^ key_m;
    return {t[119:0], t[127:120]};
  endfunction : enc

  function automatic mam_tb_q_t blk(input logic [127:0] v);
    mam_tb_q_t q;
    for (int i = 15; i >= 0; i--) q.push_back(v[i*8 +: 8]);
    return q;
  endfunction : blk

  function automatic mam_tb_q_t mk(input logic [7:0] ty, input mam_tb_q_t body);
    mam_tb_q_t  q;
    logic [15:0] len;
    logic [7:0]  s;
    len = 16'(body.size() + 1);
    q = {ty, len[7:0], len[15:8]};
    q = {q, body};
    s = 8'h00;
    foreach (q[i]) s ^= q[i];
    q.push_back(s);
    return q;
  endfunction : mk

  function automatic mam_tb_q_t raw(input logic [39:0] fr, input int n);
    mam_tb_q_t q;
    for (int i = 0; i < n; i++) q.push_back(fr[39-8*i -: 8]);
    return q;
  endfunction : raw

  function automatic mam_tb_q_t ack(input logic [7:0] c);
    mam_tb_q_t b;
    b.push_back(c);
    return mk(mam_pkg::TYPE_ERR_ACK, b);
  endfunction : ack

  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Called at a falling edge; holds each byte until the engine takes it
  task automatic send(input mam_tb_q_t q);
    foreach (q[i]) begin
      i_rx_valid = 1'b1;
      i_rx_data  = q[i];
      w = 0;
      while (o_rx_ready !== 1'b1 && w < 4000) begin
        @(negedge i_clk);
        w++;
      end
      if (w >= 4000) chk("rx ready", 128'h1, 128'(o_rx_ready));
      @(negedge i_clk);
    end
    i_rx_valid = 1'b0;
    i_rx_data  = ~i_rx_data;
  endtask : send

  task automatic exp_frame(input mam_tb_q_t e);
    w = 0;
    while (got_q.size() < e.size() && w < 4000) begin
      @(negedge i_clk);
      w++;
    end
    chk("tx frame size", 128'(e.size()), 128'(got_q.size()));
    foreach (e[i]) chk("tx byte", e[i], (got_q.size() > 0) ? got_q.pop_front() : 8'hXX);
  endtask : exp_frame

  task automatic challenge();
    w = 0;
    while (got_q.size() == 0 && w < 4000) begin
      @(negedge i_clk);
      w++;
    end
    rn = last_nonce;
    exp_frame(mk(mam_pkg::TYPE_CHALLENGE, blk(enc(rn))));
  endtask : challenge

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 40000);
    err_total++;
    close_out();
  end

  initial begin
    {i_reset_n, i_rx_valid, i_key_wr, slow} = 4'h0;
    {i_link_up, i_tx_ready} = 2'h3;
    i_rx_data = 8'h00;
    i_key_wr_data = KEY_NEW;
    key_m = mam_pkg::KEY_RESET;
    {err_total, n_checks, dreq_cnt} = {32'h0, 32'h0, 32'h0};
    repeat (3) @(negedge i_clk);
    chk("reset ready", 128'h1, o_rx_ready);
    chk("reset outputs", 128'h0, {o_tx_valid, o_rand_req, o_aes_start, o_authenticated, o_data_req});
    chk("reset session key", 128'h0, o_session_key);
    chk("reset key", mam_pkg::KEY_RESET, o_aes_key);
    i_reset_n = 1'b1;
    i_key_wr = 1'b1;
    @(negedge i_clk);
    i_key_wr = 1'b0;
    @(negedge i_clk);
    chk("key before auth", mam_pkg::KEY_RESET, o_aes_key);
    foreach (rows[r]) begin
      send(raw(rows[r].fr, rows[r].n));
      exp_frame(ack(rows[r].code));
    end
    chk("data pulses", 128'h0, 128'(dreq_cnt));
    // Slow partner, sink stalled: engine must hold off new frames
    slow = 1'b1;
    i_tx_ready = 1'b0;
    send(raw(40'h70_01_00_71_00, 4));
    repeat (60) @(negedge i_clk);
    chk("stalled valid", 128'h1, o_tx_valid);
    chk("stalled rx ready", 128'h0, o_rx_ready);
    i_tx_ready = 1'b1;
    challenge();
    c0 = enc(PEER);
    c1 = enc(~rn ^ c0);
    send(mk(mam_pkg::TYPE_PEER_REPLY, {blk(c0), blk(c1)}));
    exp_frame(ack(mam_pkg::ERR_AUTH));
    chk("auth after mismatch", 128'h0, o_authenticated);
    // Prompt partner, correct exchange
    slow = 1'b0;
    send(raw(40'h70_01_00_71_00, 4));
    challenge();
    c0 = enc(PEER);
    c1 = enc(rn ^ c0);
    send(mk(mam_pkg::TYPE_PEER_REPLY, {blk(c0), blk(c1)}));
    exp_frame(mk(mam_pkg::TYPE_COMPLETE, blk(enc(PEER))));
    chk("authenticated", 128'h1, o_authenticated);
    chk("session key", {rn[127:64], PEER[127:64]}, o_session_key);
    i_key_wr = 1'b1;
    @(negedge i_clk);
    i_key_wr = 1'b0;
    @(negedge i_clk);
    key_m = KEY_NEW;
    chk("key after auth", KEY_NEW, o_aes_key);
    send({mk(mam_pkg::TYPE_DATA_REQ, none), mk(mam_pkg::TYPE_DATA_REQ, none)});
    exp_frame({mk(mam_pkg::TYPE_DATA_RSP, none), mk(mam_pkg::TYPE_DATA_RSP, none)});
    chk("data pulses", 128'h2, 128'(dreq_cnt));
    send(raw(40'h72_01_00_00_00, 4));
    exp_frame(ack(mam_pkg::ERR_SUM));
    // Link drop ends the authenticated state
    i_link_up = 1'b0;
    repeat (2) @(negedge i_clk);
    i_link_up = 1'b1;
    chk("auth after link drop", 128'h0, o_authenticated);
    send(mk(mam_pkg::TYPE_DATA_REQ, none));
    exp_frame(ack(mam_pkg::ERR_STATE));
    chk("data pulses", 128'h2, 128'(dreq_cnt));
    i_reset_n = 1'b0;
    repeat (2) @(negedge i_clk);
    chk("mid reset key", mam_pkg::KEY_RESET, o_aes_key);
    chk("mid reset session key", 128'h0, o_session_key);
    i_reset_n = 1'b1;
    repeat (2) @(negedge i_clk);
    close_out();
  end
endmodule : tb_mutual_auth_message_engine
`default_nettype wire
